// >>> ldf_chan.sv
`timescale 1ns/1ps
`include "ldf_consts.svh"
module ldf_chan #(
   parameter int KW = `LDF_KW
) (
   input  wire logic          clk,
   input  wire logic          nrst,
   input  wire logic          tick,
   input  wire logic          run,
   input  wire logic          flush,
   input  wire logic          pk_clr,
   input  ldf_pkg::ldf_samp_t x,
   input  wire logic [KW-1:0] kdc,
   input  wire logic [KW-1:0] kac,
   output logic      [8:0]    peak,
   output ldf_pkg::ldf_acc_t  dc,
   output ldf_pkg::ldf_acc_t  ac
);
   import ldf_pkg::*;
   logic [8:0] mag;
   ldf_acc_t   next_dc;
   ldf_acc_t   next_ac;

   // single pole step y + k*(x - y)
   function automatic ldf_acc_t lp(input ldf_acc_t y, input ldf_acc_t xs, input logic [KW-1:0] k);
      logic signed [18:0]    d;
      logic signed [19+KW:0] p;
      d  = 19'(xs) - 19'(y);
      p  = d * $signed({1'b0, k});
      lp = y + ldf_acc_t'(p >>> KW);
   endfunction

   // magnitude without sign, then both filter steps
   assign mag     = x[8] ? 9'(-x) : 9'(x); // R6 R8
   assign next_dc = lp(dc, ldf_acc_t'(signed'({x, `LDF_FRAC'h00})), kdc); // R7 R21
   assign next_ac = lp(ac, ldf_acc_t'({1'b0, mag, `LDF_FRAC'h00}), kac); // R8 R21

   // peak hold, cleared by flush or host restart
   always_ff @(posedge clk) begin
      if (!nrst) begin
         peak <= '0;
      end else if (flush || pk_clr) begin // R10 R11
         peak <= '0;
      end else if (run && tick && mag > peak) begin // R2 R6
         peak <= mag;
      end
   end

   // filter states, one step per monitor sample
   always_ff @(posedge clk) begin
      if (!nrst) begin
         dc <= '0;
         ac <= '0;
      end else if (flush) begin // R10
         dc <= '0;
         ac <= '0;
      end else if (run && tick) begin // R2 R21
         dc <= next_dc;
         ac <= next_ac;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   AST_IDLE: assert property (!run && !flush && !pk_clr |=> $stable(dc) && $stable(ac) && $stable(peak)) // R2
      else $error("filters moved while idle");
   AST_PEAK: assert property (run && tick && !flush && !pk_clr |=> peak >= $past(mag)) // R6
      else $error("peak below last magnitude");
   AST_DCSTEP: assert property (run && tick && !flush |=> dc == $past(next_dc) && ac == $past(next_ac)) // R21
      else $error("filter step not taken");
   COV_PEAK: cover property (run && tick && mag > peak);
endmodule

// >>> ldf_consts.svh
`ifndef LDF_CONSTS_SVH
`define LDF_CONSTS_SVH
// sample rate timing
`define LDF_CLK_HZ    200000000
`define LDF_SAMPLE_HZ 800
`define LDF_TICK_CYC  (`LDF_CLK_HZ / `LDF_SAMPLE_HZ)
// coefficient width and fraction bits of the filter state
`define LDF_KW   8
`define LDF_FRAC 8
// address layout: channel select bit, lowest bit that must be zero
`define LDF_CH_BIT   6
`define LDF_ADDR_TOP 7
// byte offsets inside one channel
`define LDF_O_CTRL 6'h00
`define LDF_O_KDC  6'h04
`define LDF_O_KAC  6'h08
`define LDF_O_PEAK 6'h0C
`define LDF_O_DC   6'h10
`define LDF_O_AC   6'h14
`define LDF_O_VMON 6'h18
`define LDF_O_IMON 6'h1C
`define LDF_O_FEED 6'h20
`define LDF_O_TONE 6'h24
// field positions
`define LDF_F_EN   0
`define LDF_F_SRC  1
`define LDF_F_LONG 16
`define LDF_F_CUR  0
`define LDF_F_OCV  8
`define LDF_F_POL  16
`define LDF_F_LOW  17
`define LDF_F_T1   0
`define LDF_F_T2   1
`define LDF_F_RX   2
`define LDF_F_RGEN 8
`define LDF_F_UNB  9
// reset values
`define LDF_RST_KDC 8'h08
`define LDF_RST_KAC 8'h08
`define LDF_RST_CUR 5'h0A
`define LDF_RST_OCV 6'h30
`endif

// >>> ldf_pkg.sv
package ldf_pkg;
   // diagnostic input source codes
   typedef enum logic [2:0] {
      LDF_SRC_TIP_V  = 3'b000,
      LDF_SRC_RING_V = 3'b001,
      LDF_SRC_LOOP_V = 3'b010,
      LDF_SRC_LONG_V = 3'b011,
      LDF_SRC_LOOP_I = 3'b100,
      LDF_SRC_LONG_I = 3'b101,
      LDF_SRC_EXT_V  = 3'b110,
      LDF_SRC_EXT_I  = 3'b111
   } ldf_src_t;
   typedef logic signed [8:0]  ldf_samp_t;
   typedef logic signed [17:0] ldf_acc_t;
endpackage

// >>> ldf_sync.sv
`timescale 1ns/1ps
module ldf_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;
   // two-stage synchroniser, meta read only by q
   always_ff @(posedge clk) begin
      if (!nrst) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

// >>> ldf_tb.sv
`timescale 1ns/1ps
`include "ldf_consts.svh"
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== 32'(ex)) begin err_count++; \
   $display("FAIL %s expected %h seen %h", nm, 32'(ex), gt); end end
module tb;
   logic            clk;
   logic            nrst;
   logic            psel;
   logic            penable;
   logic            pwrite;
   logic [31:0]     paddr;
   logic [31:0]     pwdata;
   logic [1:0][7:0] tip_v, ring_v, tip_i, ring_i, ext_v, ext_i;
   logic [1:0]      off_hook, ring_trip, voice;
   wire  [31:0]     prdata;
   wire             pready, pslverr, mon_strobe;
   wire  [1:0]      low_rng, pol_rev, tone1, tone2, tone_rx, dring, unbal, diagnostic_control_register_act;
   wire  [1:0][4:0] feed_cur;
   wire  [1:0][5:0] oc_volt;
   int              err_count, comparisons;
   int              ch, s, i, b, x, pe, dc, ac, kd, ka;
   int              last_dc[2];
   logic [31:0]     r, d;

   ldf_top #(.TICK_DIV(8)) dut (.CORE_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TIP_V(tip_v),
      .RING_V(ring_v), .TIP_I(tip_i), .RING_I(ring_i), .EXT_RV(ext_v), .EXT_RI(ext_i), .OFF_HOOK(off_hook),
      .RING_TRIP(ring_trip), .VOICE_ACT(voice), .MON_STROBE(mon_strobe), .MON_LOW_RANGE(low_rng),
      .FEED_CUR(feed_cur), .OC_VOLT(oc_volt), .POL_REV(pol_rev), .TONE1_EN(tone1), .TONE2_EN(tone2),
      .TONE_TO_RX(tone_rx), .DRING_EN(dring), .DRING_UNBAL(unbal), .DIAGNOSTIC_CONTROL_REGISTER_ACTIVE(diagnostic_control_register_act));

   // 200 MHz core clock
   always #2.5 clk = ~clk;

   // verdict and end of run
   task summarize;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic e);
      int n;
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      e  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n == 20) begin
         err_count++;
         summarize();
      end
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, v, q, e);
   endtask

   task automatic rd_chk(input logic [31:0] a, input int ex, input logic ee, input string nm);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      `CHK(nm, ex, q)
      `CHK("slave error", ee, e)
   endtask

   // returns at the edge where the sample strobe is seen
   task automatic wait_strobe;
      int n;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (mon_strobe === 1'b1) break;
      end
      if (n == 20) begin
         err_count++;
         summarize();
      end
   endtask

   // difference in low half, halved sum in upper half
   function automatic int mon_word(int a, int c);
      return ((((a + c) >>> 1) & 'h1FF) << 16) | ((a - c) & 'h1FF);
   endfunction

   // selected source value from the applied samples
   function automatic int src_val(int c, int sel);
      int t, q, ti, ri;
      t  = $signed(tip_v[c]);
      q  = $signed(ring_v[c]);
      ti = $signed(tip_i[c]);
      ri = $signed(ring_i[c]);
      case (sel)
         0: return t;
         1: return q;
         2: return t - q;
         3: return (t + q) >>> 1;
         4: return ti - ri;
         5: return (ti + ri) >>> 1;
         6: return $signed(ext_v[c]);
         default: return $signed(ext_i[c]);
      endcase
   endfunction

   // single-pole low-pass step, 8 fraction bits
   function automatic int stp(int y, int k, int xin);
      return y + ((k * (xin * 256 - y)) >>> 8);
   endfunction

   // main sequence
   initial begin
      clk = 0;
      nrst = 0;
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = 0;
      pwdata = 0;
      tip_v = 0;
      ring_v = 0;
      tip_i = 0;
      ring_i = 0;
      ext_v = 0;
      ext_i = 0;
      off_hook = 0;
      ring_trip = 0;
      voice = 2'b11;
      void'($urandom(32'h35D1));
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      for (ch = 0; ch < 2; ch++) begin
         b = ch * 64;
         rd_chk(b + `LDF_O_CTRL, 0, 1'b0, "ctrl reset");
         rd_chk(b + `LDF_O_KDC, `LDF_RST_KDC, 1'b0, "dc coeff reset");
         rd_chk(b + `LDF_O_KAC, `LDF_RST_KAC, 1'b0, "ac coeff reset");
         rd_chk(b + `LDF_O_PEAK, 0, 1'b0, "peak reset");
         rd_chk(b + `LDF_O_FEED, 32'h300A, 1'b0, "feed reset");
      end
      rd_chk(32'h28, 0, 1'b1, "unmapped");
      rd_chk(32'h80, 0, 1'b1, "high address");
      $display("test reset_and_map done");
      for (i = 0; i < 4; i++) begin
         ch = i % 2;
         b = ch * 64;
         r = $urandom;
         wr(b + `LDF_O_FEED, r);
         rd_chk(b + `LDF_O_FEED, r & 32'h33F1F, 1'b0, "feed");
         `CHK("feed current", r[4:0], feed_cur[ch])
         `CHK("open volt", r[13:8], oc_volt[ch])
         `CHK("reversal", r[16], pol_rev[ch])
         `CHK("low range", r[17], low_rng[ch])
         r = $urandom;
         wr(b + `LDF_O_TONE, r);
         rd_chk(b + `LDF_O_TONE, r & 32'h307, 1'b0, "tone");
         `CHK("tone one", r[0], tone1[ch])
         `CHK("tone two", r[1], tone2[ch])
         `CHK("tone route", r[2], tone_rx[ch])
         `CHK("diagnostic_control_register ring", r[8], dring[ch])
         `CHK("unbalanced", r[9], unbal[ch])
      end
      $display("test line_settings done");
      for (s = 0; s < 8; s++) begin
         ch = s % 2;
         b = ch * 64;
         tip_v[ch] <= 8'($urandom);
         ring_v[ch] <= 8'($urandom);
         tip_i[ch] <= 8'($urandom);
         ring_i[ch] <= 8'($urandom);
         ext_v[ch] <= 8'($urandom);
         ext_i[ch] <= 8'($urandom);
         kd = $urandom_range(255, 1);
         ka = $urandom_range(255, 1);
         wr(b + `LDF_O_KDC, kd);
         wr(b + `LDF_O_KAC, ka);
         wait_strobe();
         voice[ch] <= 1'b0;
         wr(b + `LDF_O_CTRL, 1 | (s << 1));
         x = src_val(ch, s);
         pe = (x < 0) ? -x : x;
         dc = stp(0, kd, x);
         ac = stp(0, ka, pe);
         wait_strobe();
         voice[ch] <= 1'b1;
         rd_chk(b + `LDF_O_PEAK, pe, 1'b0, "peak");
         rd_chk(b + `LDF_O_DC, dc & 'h3FFFF, 1'b0, "dc result");
         rd_chk(b + `LDF_O_AC, ac & 'h3FFFF, 1'b0, "ac result");
         rd_chk(b + `LDF_O_VMON, mon_word($signed(tip_v[ch]), $signed(ring_v[ch])), 1'b0, "vmon");
         rd_chk(b + `LDF_O_IMON, mon_word($signed(tip_i[ch]), $signed(ring_i[ch])), 1'b0, "imon");
         `CHK("active in voice", 0, diagnostic_control_register_act[ch])
         wr(b + `LDF_O_PEAK, 5);
         rd_chk(b + `LDF_O_PEAK, pe, 1'b0, "peak kept");
         wr(b + `LDF_O_PEAK, 0);
         rd_chk(b + `LDF_O_PEAK, 0, 1'b0, "peak cleared");
         wait_strobe();
         voice[ch] <= 1'b0;
         wait_strobe();
         voice[ch] <= 1'b1;
         dc = stp(dc, kd, x);
         ac = stp(ac, ka, pe);
         last_dc[ch] = dc;
         rd_chk(b + `LDF_O_PEAK, pe, 1'b0, "peak again");
         rd_chk(b + `LDF_O_DC, dc & 'h3FFFF, 1'b0, "dc second");
         rd_chk(b + `LDF_O_AC, ac & 'h3FFFF, 1'b0, "ac second");
      end
      rd_chk(`LDF_O_DC, last_dc[0] & 'h3FFFF, 1'b0, "other channel dc");
      $display("test filter_paths done");
      for (ch = 0; ch < 2; ch++) begin
         b = ch * 64;
         // voice off, so only the hook or trip clear keeps the channel inactive
         voice[ch] <= 1'b0;
         if (ch == 0) off_hook[0] <= 1'b1;
         else ring_trip[1] <= 1'b1;
         repeat (5) @(posedge clk);
         wr(b + `LDF_O_CTRL, 32'h3);
         apb(1'b0, b + `LDF_O_CTRL, 32'h0, d, r[0]);
         `CHK("enable cleared", 0, d[0])
         `CHK("active cleared", 0, diagnostic_control_register_act[ch])
         off_hook <= 2'b00;
         ring_trip <= 2'b00;
         wait_strobe();
         wait_strobe();
         // enable rise flushed the state, no step since the clear
         rd_chk(b + `LDF_O_DC, 0, 1'b0, "idle dc");
      end
      $display("test hook_abort done");
      summarize();
   end
endmodule

// >>> ldf_top.sv
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "ldf_consts.svh"
// Notes on behaviour
// R1: three-bit source code picks tip, ring, loop, long voltage, currents, external ring.
// R2: post-processing filters run only while diagnostics are enabled.
// R3: each channel has its own independent filter set and control.
// R4: filters step only while no voice-band processing runs on that channel.
// R5: off-hook or ring trip while enabled clears the enable and stops processing.
// R6: peak detector holds largest magnitude, unsigned, of either polarity.
// R7: dc path is single-pole low-pass, own coefficient, result readable.
// R8: ac path rectifies then single-pole low-pass with its own coefficient.
// R9: current peak magnitude readable at the peak location.
// R10: enable rising or source change clears peak and flushes both filters.
// R11: host writing zero to peak location restarts peak capture.
// R12: monitor samples are 8-bit tip and ring voltages and currents at 800 Hz.
// R13: tip minus ring and tip plus ring values computed and stored per sample.
// R14: monitor converter has high and low range selection.
// R15: constant-current feed setting register drives the feed converter.
// R16: open-circuit voltage setting spans 0 to 63 in unit steps.
// R17: linefeed can be commanded to reverse polarity.
// R18: single or dual tone enables with transmit or receive routing.
// R19: diagnostic ringing balanced or unbalanced per its control bit.
// R20: host loads parameters, starts test, then reads results back.
// R21: each low-pass updates once per sample as y plus k times x minus y.
module ldf_top #(
   parameter int TICK_DIV = `LDF_TICK_CYC,
   parameter int KW       = `LDF_KW
) (
   input  wire logic            CORE_CLK,
   input  wire logic            NRST,
   input  wire logic            PSEL,
   input  wire logic            PENABLE,
   input  wire logic            PWRITE,
   input  wire logic [31:0]     PADDR,
   input  wire logic [31:0]     PWDATA,
   output logic      [31:0]     PRDATA,
   output logic                 PREADY,
   output logic                 PSLVERR,
   input  wire logic [1:0][7:0] TIP_V,
   input  wire logic [1:0][7:0] RING_V,
   input  wire logic [1:0][7:0] TIP_I,
   input  wire logic [1:0][7:0] RING_I,
   input  wire logic [1:0][7:0] EXT_RV,
   input  wire logic [1:0][7:0] EXT_RI,
   input  wire logic [1:0]      OFF_HOOK,
   input  wire logic [1:0]      RING_TRIP,
   input  wire logic [1:0]      VOICE_ACT,
   output logic                 MON_STROBE,
   output logic      [1:0]      MON_LOW_RANGE,
   output logic      [1:0][4:0] FEED_CUR,
   output logic      [1:0][5:0] OC_VOLT,
   output logic      [1:0]      POL_REV,
   output logic      [1:0]      TONE1_EN,
   output logic      [1:0]      TONE2_EN,
   output logic      [1:0]      TONE_TO_RX,
   output logic      [1:0]      DRING_EN,
   output logic      [1:0]      DRING_UNBAL,
   output logic      [1:0]      DIAGNOSTIC_CONTROL_REGISTER_ACTIVE
);
   import ldf_pkg::*;

   logic [101:0]    sync_q;
   logic [1:0][7:0] s_tip_v;
   logic [1:0][7:0] s_ring_v;
   logic [1:0][7:0] s_tip_i;
   logic [1:0][7:0] s_ring_i;
   logic [1:0][7:0] s_ext_rv;
   logic [1:0][7:0] s_ext_ri;
   logic [1:0]      s_hook;
   logic [1:0]      s_trip;
   logic [1:0]      s_voice;
   logic [31:0]     div_cnt;
   logic [1:0]      ctl_en;
   ldf_src_t        ctl_src [2];
   logic [KW-1:0]   kdc [2];
   logic [KW-1:0]   kac [2];
   logic [1:0]      en_q;
   ldf_src_t        src_q [2];
   logic [1:0]      flush;
   logic [1:0]      run;
   logic [1:0]      pk_clr;
   ldf_samp_t       tv [2];
   ldf_samp_t       rv [2];
   ldf_samp_t       ti [2];
   ldf_samp_t       ri [2];
   ldf_samp_t       vl [2];
   ldf_samp_t       vg [2];
   ldf_samp_t       il [2];
   ldf_samp_t       ig [2];
   ldf_samp_t       x [2];
   ldf_samp_t       mon_vl [2];
   ldf_samp_t       mon_vg [2];
   ldf_samp_t       mon_il [2];
   ldf_samp_t       mon_ig [2];
   logic [8:0]      peak [2];
   ldf_acc_t        dc [2];
   ldf_acc_t        ac [2];
   logic            acc;
   logic            wr;
   logic            ch;
   logic [5:0]      off;
   logic [31:0]     rd;

   // mapped word check, used for errors and writes
   function automatic logic mapped(input logic [31:0] a);
      logic hit;
      case (a[5:0])
         `LDF_O_CTRL, `LDF_O_KDC, `LDF_O_KAC, `LDF_O_PEAK, `LDF_O_DC,
         `LDF_O_AC, `LDF_O_VMON, `LDF_O_IMON, `LDF_O_FEED, `LDF_O_TONE: hit = 1'b1;
         default: hit = 1'b0;
      endcase
      mapped = hit && (a[31:`LDF_ADDR_TOP] == '0);
   endfunction

   // all sample and line status pin inputs pass two flops, the apb inputs do not
   ldf_sync #(
      .W(102)
   ) u_sync (
      .clk (CORE_CLK),
      .nrst(NRST),
      .d   ({EXT_RI, EXT_RV, RING_I, TIP_I, RING_V, TIP_V, VOICE_ACT, RING_TRIP, OFF_HOOK}),
      .q   (sync_q)
   );
   assign {s_ext_ri, s_ext_rv, s_ring_i, s_tip_i, s_ring_v, s_tip_v, s_voice, s_trip, s_hook} = sync_q;

   // 800 Hz sample enable from the core clock
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         div_cnt    <= '0;
         MON_STROBE <= 1'b0;
      end else if (div_cnt == 32'(TICK_DIV - 1)) begin // R12
         div_cnt    <= '0;
         MON_STROBE <= 1'b1;
      end else begin
         div_cnt    <= div_cnt + 32'h1;
         MON_STROBE <= 1'b0;
      end
   end

   // derived metallic and longitudinal values, source mux
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         tv[c] = {s_tip_v[c][7], s_tip_v[c]};
         rv[c] = {s_ring_v[c][7], s_ring_v[c]};
         ti[c] = {s_tip_i[c][7], s_tip_i[c]};
         ri[c] = {s_ring_i[c][7], s_ring_i[c]};
         vl[c] = tv[c] - rv[c]; // R13
         vg[c] = ldf_samp_t'((10'(tv[c]) + 10'(rv[c])) >>> 1); // R13
         il[c] = ti[c] - ri[c];
         ig[c] = ldf_samp_t'((10'(ti[c]) + 10'(ri[c])) >>> 1);
         case (ctl_src[c]) // R1
            LDF_SRC_TIP_V:  x[c] = tv[c];
            LDF_SRC_RING_V: x[c] = rv[c];
            LDF_SRC_LOOP_V: x[c] = vl[c];
            LDF_SRC_LONG_V: x[c] = vg[c];
            LDF_SRC_LOOP_I: x[c] = il[c];
            LDF_SRC_LONG_I: x[c] = ig[c];
            LDF_SRC_EXT_V:  x[c] = {s_ext_rv[c][7], s_ext_rv[c]};
            LDF_SRC_EXT_I:  x[c] = {s_ext_ri[c][7], s_ext_ri[c]};
            default:        x[c] = '0;
         endcase
      end
   end

   // stored monitor results, refreshed each sample
   always_ff @(posedge CORE_CLK) begin
      for (int c = 0; c < 2; c++) begin
         if (!NRST) begin
            mon_vl[c] <= '0;
            mon_vg[c] <= '0;
            mon_il[c] <= '0;
            mon_ig[c] <= '0;
         end else if (MON_STROBE) begin // R12 R13
            mon_vl[c] <= vl[c];
            mon_vg[c] <= vg[c];
            mon_il[c] <= il[c];
            mon_ig[c] <= ig[c];
         end
      end
   end

   // enable edge and source change history
   always_ff @(posedge CORE_CLK) begin
      for (int c = 0; c < 2; c++) begin
         if (!NRST) begin
            en_q[c]  <= 1'b0;
            src_q[c] <= LDF_SRC_TIP_V;
         end else begin
            en_q[c]  <= ctl_en[c];
            src_q[c] <= ctl_src[c];
         end
      end
   end

   // flush, run and peak restart per channel
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         flush[c]  = (ctl_en[c] && !en_q[c]) || (ctl_src[c] != src_q[c]); // R10
         run[c]    = ctl_en[c] && !s_voice[c]; // R2 R4
         pk_clr[c] = wr && (ch == c[0]) && mapped(PADDR) && (off == `LDF_O_PEAK) && (PWDATA == 32'h0); // R11
      end
   end

   // activity flag out of a flop
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         DIAGNOSTIC_CONTROL_REGISTER_ACTIVE <= '0;
      end else begin
         DIAGNOSTIC_CONTROL_REGISTER_ACTIVE <= run; // R4
      end
   end

   // one independent filter set per channel
   for (genvar c = 0; c < 2; c++) begin : g_ch // R3
      ldf_chan #(
         .KW(KW)
      ) u_chan (
         .clk   (CORE_CLK),
         .nrst  (NRST),
         .tick  (MON_STROBE),
         .run   (run[c]),
         .flush (flush[c]),
         .pk_clr(pk_clr[c]),
         .x     (x[c]),
         .kdc   (kdc[c]),
         .kac   (kac[c]),
         .peak  (peak[c]),
         .dc    (dc[c]),
         .ac    (ac[c])
      );
   end

   // apb decode, one wait state per access
   assign acc = PSEL && PENABLE;
   assign wr  = acc && PREADY && PWRITE;
   assign ch  = PADDR[`LDF_CH_BIT];
   assign off = PADDR[5:0];

   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         PREADY <= 1'b0;
      end else begin
         PREADY <= acc && !PREADY;
      end
   end

   // read mux over the selected channel
   always_comb begin
      rd = 32'h0;
      case (off)
         `LDF_O_CTRL: begin
            rd[`LDF_F_EN]       = ctl_en[ch];
            rd[`LDF_F_SRC +: 3] = ctl_src[ch];
         end
         `LDF_O_KDC:  rd[KW-1:0] = kdc[ch];
         `LDF_O_KAC:  rd[KW-1:0] = kac[ch];
         `LDF_O_PEAK: rd[8:0] = peak[ch]; // R9
         `LDF_O_DC:   rd[17:0] = dc[ch]; // R7
         `LDF_O_AC:   rd[17:0] = ac[ch]; // R8
         `LDF_O_VMON: begin
            rd[8:0]                = mon_vl[ch];
            rd[`LDF_F_LONG +: 9]   = mon_vg[ch];
         end
         `LDF_O_IMON: begin
            rd[8:0]                = mon_il[ch];
            rd[`LDF_F_LONG +: 9]   = mon_ig[ch];
         end
         `LDF_O_FEED: begin
            rd[`LDF_F_CUR +: 5] = FEED_CUR[ch];
            rd[`LDF_F_OCV +: 6] = OC_VOLT[ch];
            rd[`LDF_F_POL]      = POL_REV[ch];
            rd[`LDF_F_LOW]      = MON_LOW_RANGE[ch];
         end
         `LDF_O_TONE: begin
            rd[`LDF_F_T1]   = TONE1_EN[ch];
            rd[`LDF_F_T2]   = TONE2_EN[ch];
            rd[`LDF_F_RX]   = TONE_TO_RX[ch];
            rd[`LDF_F_RGEN] = DRING_EN[ch];
            rd[`LDF_F_UNB]  = DRING_UNBAL[ch];
         end
         default: rd = 32'h0;
      endcase
   end

   // read data and error captured one cycle ahead of ready
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         PRDATA  <= 32'h0;
         PSLVERR <= 1'b0;
      end else if (acc && !PREADY) begin
         PRDATA  <= (PWRITE || !mapped(PADDR)) ? 32'h0 : rd;
         PSLVERR <= !mapped(PADDR);
      end else begin
         PRDATA  <= 32'h0;
         PSLVERR <= 1'b0;
      end
   end

   // register writes, hook or trip clear wins over a write while the enable is already set
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         ctl_en        <= '0;
         FEED_CUR      <= {2{`LDF_RST_CUR}};
         OC_VOLT       <= {2{`LDF_RST_OCV}};
         POL_REV       <= '0;
         MON_LOW_RANGE <= '0;
         TONE1_EN      <= '0;
         TONE2_EN      <= '0;
         TONE_TO_RX    <= '0;
         DRING_EN      <= '0;
         DRING_UNBAL   <= '0;
         for (int c = 0; c < 2; c++) begin
            ctl_src[c] <= LDF_SRC_TIP_V;
            kdc[c]     <= `LDF_RST_KDC;
            kac[c]     <= `LDF_RST_KAC;
         end
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (wr && (ch == c[0]) && mapped(PADDR)) begin
               case (off)
                  `LDF_O_CTRL: begin
                     ctl_en[c]  <= PWDATA[`LDF_F_EN]; // R2
                     ctl_src[c] <= ldf_src_t'(PWDATA[`LDF_F_SRC +: 3]); // R1
                  end
                  `LDF_O_KDC: kdc[c] <= PWDATA[KW-1:0]; // R7
                  `LDF_O_KAC: kac[c] <= PWDATA[KW-1:0]; // R8
                  `LDF_O_FEED: begin
                     FEED_CUR[c]      <= PWDATA[`LDF_F_CUR +: 5]; // R15
                     OC_VOLT[c]       <= PWDATA[`LDF_F_OCV +: 6]; // R16
                     POL_REV[c]       <= PWDATA[`LDF_F_POL]; // R17
                     MON_LOW_RANGE[c] <= PWDATA[`LDF_F_LOW]; // R14
                  end
                  `LDF_O_TONE: begin
                     TONE1_EN[c]    <= PWDATA[`LDF_F_T1]; // R18
                     TONE2_EN[c]    <= PWDATA[`LDF_F_T2]; // R18
                     TONE_TO_RX[c]  <= PWDATA[`LDF_F_RX]; // R18
                     DRING_EN[c]    <= PWDATA[`LDF_F_RGEN]; // R19
                     DRING_UNBAL[c] <= PWDATA[`LDF_F_UNB]; // R19
                  end
                  default: ;
               endcase
            end
            if (ctl_en[c] && (s_hook[c] || s_trip[c])) begin // R5
               ctl_en[c] <= 1'b0;
            end
         end
      end
   end

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);
   AST_AUTO_CLR: assert property (ctl_en[0] && (s_hook[0] || s_trip[0]) |=> !ctl_en[0] && !run[0]) // R5
      else $error("enable not cleared on hook or trip");
   AST_FLUSH: assert property (flush[1] |=> peak[1] == 9'h000 && dc[1] == '0 && ac[1] == '0) // R10
      else $error("flush left state behind");
   AST_VOICE: assert property (s_voice[1] |=> !DIAGNOSTIC_CONTROL_REGISTER_ACTIVE[1]) // R4
      else $error("active during voice processing");
   AST_PKCLR: assert property (pk_clr[0] |=> peak[0] == 9'h000) // R11
      else $error("peak not restarted");
   AST_MUX: assert property (ctl_src[0] == LDF_SRC_LOOP_V |-> // R1
      x[0] == ldf_samp_t'($signed({s_tip_v[0][7], s_tip_v[0]}) - $signed({s_ring_v[0][7], s_ring_v[0]})))
      else $error("wrong source selected");
   AST_MON: assert property (MON_STROBE |=> mon_vl[1] == $past(vl[1]) && mon_vg[1] == $past(vg[1])) // R13
      else $error("monitor values not stored");
   AST_TICK: assert property (MON_STROBE |=> !MON_STROBE [*2]) // R12
      else $error("sample enable too dense");
   AST_FEED: assert property (wr && !ch && mapped(PADDR) && off == `LDF_O_FEED |=> // R16
      OC_VOLT[0] == 6'($past(PWDATA) >> `LDF_F_OCV))
      else $error("voltage setting not applied");
   AST_RDY: assert property (acc && !PREADY |=> PREADY ##1 !PREADY) // R20
      else $error("apb ready timing broken");
   COV_FLUSH: cover property (flush[0] ##1 run[0]);
   COV_TRIP: cover property (ctl_en[1] && s_trip[1]);
   COV_READ_PEAK: cover property (acc && PREADY && !PWRITE && off == `LDF_O_PEAK);
endmodule
